// *** io34_asserts.sv ***
// Concurrent checks on the port 3 / port 4 I/O block
`timescale 1ns/1ps
`default_nettype none
`include "io34_defs.vh"
module io34_asserts (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [15:0] addr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic [2:0] op_mode,
    input wire logic serial3_tx_en,
    input wire logic serial3_rx_en,
    input wire logic [1:0] serial3_clk_en,
    input wire logic ser3_txd,
    input wire logic [7:0] p3_out,
    input wire logic [7:0] p3_oe,
    input wire logic [7:0] p3_pullup_on,
    input wire logic [3:0] p4_in,
    input wire logic [2:0] p4_out,
    input wire logic [2:0] p4_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_rd_p4;
        ce && rd && addr == `IO34_ADDR_P4_DATA;
    endsequence
    sequence s_act;
        ce && op_mode == `IO34_MODE_ACTIVE;
    endsequence
    a_reset_pins_off: assert property ($rose(rstn) |-> p3_oe == 8'h00 && p3_pullup_on == 8'h00)
        else $error("pins not idle after reset");
    a_rdata_idle: assert property (ce && !rd |=> rdata == 8'h00)
        else $error("read data not cleared");
    a_dir_reads_ones: assert property (ce && rd && addr == `IO34_ADDR_P4_DIR |=> rdata == 8'hFF)
        else $error("direction read not all ones");
    a_upper_read_ones: assert property (s_rd_p4 |=> rdata[7:4] == 4'hF)
        else $error("upper data bits not ones");
    a_bit3_pin: assert property (s_rd_p4 ##0 ($stable(p4_in[3]) && $past(rstn, 3)
        && $past(p4_in[3], 2) == p4_in[3]) |=> rdata[3] == $past(p4_in[3], 3))
        else $error("bit 3 read not pin");
    a_standby_hiz: assert property (ce && op_mode == `IO34_MODE_STANDBY |=> p3_oe == 8'h00)
        else $error("pins driven in standby");
    a_sleep_hold: assert property (ce && op_mode inside {`IO34_MODE_SLEEP, `IO34_MODE_SUBSLEEP,
        `IO34_MODE_WATCH} |=> $stable(p3_oe) && $stable(p3_out))
        else $error("pins changed in hold mode");
    a_txd_drives: assert property (s_act ##0 serial3_tx_en |=> p4_oe[2] && p4_out[2] == $past(ser3_txd))
        else $error("transmit pin not driven");
    a_rxd_input: assert property (s_act ##0 serial3_rx_en |=> !p4_oe[1])
        else $error("receive pin driven");
    a_sck3_input: assert property (s_act ##0 serial3_clk_en[1] |=> !p4_oe[0])
        else $error("clock input pin driven");
endmodule // io34_asserts
bind io34_top io34_asserts chk (.mclk(mclk), .rstn(rstn), .ce(ce), .addr(addr), .rd(rd),
    .rdata(rdata), .op_mode(op_mode), .serial3_tx_en(serial3_tx_en),
    .serial3_rx_en(serial3_rx_en), .serial3_clk_en(serial3_clk_en), .ser3_txd(ser3_txd),
    .p3_out(p3_out), .p3_oe(p3_oe), .p3_pullup_on(p3_pullup_on), .p4_in(p4_in),
    .p4_out(p4_out), .p4_oe(p4_oe));
`default_nettype wire

// *** io34_defs.vh ***
// Constants for the port 3 / port 4 general-purpose I/O block
//
// Behaviour
// - Serial data select owns pin, else direction bit
// - Serial2 input select forces bit 4 input
// - Serial2 clock: source 111 input, else output
// - Serial1 clock: source bit 1 input, 0 output
// - Port 3 Hi-Z reset/standby, hold sleep modes
// - Standby pin with pull-up on reads high
// - Pull-up on only if direction bit input and enabled
// - All port 3 pull-ups off after reset
// - Port 4: bits 2-0 bidirectional, bit 3 input
// - Port 4 output bits read stored data
// - Port 4 input bits read pin level
// - Port 4 direction 1 output, 0 input
// - Serial3 control overrides port 4 settings
// - Port 4 direction write-only, reads all ones
// - Port 4 data and direction reset F8
// - Port 4 data bit 3 read-only pin
// - Port 3 function select resets to zero
`ifndef IO34_DEFS_VH
`define IO34_DEFS_VH

`define IO34_ADDR_W 16
`define IO34_ADDR_P3_FUNC 16'hFFCA
`define IO34_ADDR_P3_DATA 16'hFFD6
`define IO34_ADDR_P3_DIR 16'hFFE6
`define IO34_ADDR_P3_PULLUP 16'hFFE1
`define IO34_ADDR_P4_DATA 16'hFFD7
`define IO34_ADDR_P4_DIR 16'hFFE7

`define IO34_P3_FUNC_RESET 8'h00
`define IO34_P3_DATA_RESET 8'h00
`define IO34_P3_DIR_RESET 8'h00
`define IO34_P3_PULLUP_RESET 8'h00
`define IO34_P4_RESET 8'hF8
`define IO34_UNMAPPED_READ 8'h00

// Field positions in the port 3 function select register
`define IO34_F_SERIAL1_CLOCK_SELECT 0
`define IO34_F_SI1 1
`define IO34_F_SO1 2
`define IO34_F_SERIAL2_CLOCK_SELECT 3
`define IO34_F_SI2 4
`define IO34_F_SO2 5

`define IO34_SERIAL2_CLOCK_SELECT_EXT_SRC 3'h7

// Operating modes
`define IO34_MODE_ACTIVE 3'h0
`define IO34_MODE_SUBACTIVE 3'h1
`define IO34_MODE_SLEEP 3'h2
`define IO34_MODE_SUBSLEEP 3'h3
`define IO34_MODE_WATCH 3'h4
`define IO34_MODE_STANDBY 3'h5

`endif

// *** io34_pins.sv ***
// Board-level pin model for ports 3 and 4
`timescale 1ns/1ps
`default_nettype none
module io34_pins (
    input wire logic [7:0] p3_out,
    input wire logic [7:0] p3_oe,
    input wire logic [7:0] p3_pullup_on,
    input wire logic [2:0] p4_out,
    input wire logic [2:0] p4_oe,
    input wire logic [3:0] p4_ext,
    output logic [7:0] p3_in,
    output logic [3:0] p4_in
);
    // Undriven port 3 pins float away from their last drive value unless pulled up; undriven port 4 pins and bit 3 follow p4_ext
    assign p3_in = (p3_oe & p3_out) | (~p3_oe & (p3_pullup_on | ~p3_out));
    assign p4_in = {p4_ext[3], (p4_oe & p4_out) | (~p4_oe & p4_ext[2:0])};
endmodule // io34_pins
`default_nettype wire

// *** io34_sync.v ***
// Two-flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module io34_sync #(
    parameter W = 8
) (
    input wire mclk,
    input wire rstn,
    input wire ce,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta_r;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else if (ce) begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // io34_sync
`default_nettype wire

// *** io34_top.v ***
// Port 3 and port 4 general-purpose I/O with serial pin sharing
`timescale 1ns/1ps
`default_nettype none
`include "io34_defs.vh"
module io34_top (
    input wire mclk,
    input wire rstn,
    input wire ce,
    // Register port
    input wire [15:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    // Operating mode from the power controller
    input wire [2:0] op_mode,
    // Serial channel settings
    input wire serial1_clock_source,
    input wire [2:0] serial2_clock_source,
    input wire serial3_tx_en,
    input wire serial3_rx_en,
    input wire [1:0] serial3_clk_en,
    input wire serial3_sync_mode,
    // Serial channel signals
    input wire ser1_data_out,
    input wire ser1_clk_out,
    input wire ser2_data_out,
    input wire ser2_clk_out,
    input wire ser3_txd,
    input wire ser3_clk_out,
    output reg ser1_data_in,
    output reg ser1_clk_in,
    output reg ser2_data_in,
    output reg ser2_clk_in,
    output reg ser3_rxd,
    output reg ser3_clk_in,
    // Port 3 pins
    input wire [7:0] p3_in,
    output reg [7:0] p3_out,
    output reg [7:0] p3_oe,
    output reg [7:0] p3_pullup_on,
    // Port 4 pins
    input wire [3:0] p4_in,
    output reg [2:0] p4_out,
    output reg [2:0] p4_oe
);
    reg [7:0] port3_function_select_r;
    reg [7:0] port3_data_r;
    reg [7:0] port3_direction_r;
    reg [7:0] port3_pullup_enable_r;
    reg [2:0] port4_data_r;
    reg [2:0] port4_direction_r;

    wire [7:0] p3_pin;
    wire [3:0] p4_pin;

    reg [7:0] p3_out_nxt;
    reg [7:0] p3_oe_nxt;
    reg [7:0] p3_pu_nxt;
    reg [2:0] p4_out_nxt;
    reg [2:0] p4_oe_nxt;
    reg [7:0] rdata_nxt;
    reg serial2_clock_select_as_out;
    reg sck3_as_out;
    reg sck3_as_in;

    wire mode_hiz;
    wire mode_hold;

    localparam [7:0] P4_RESET = `IO34_P4_RESET;

    // Bit read: output bits give stored data, input bits give pin level
    function [7:0] io34_read_mux;
        input [7:0] dir;
        input [7:0] data;
        input [7:0] pin;
        begin
            io34_read_mux = (dir & data) | (~dir & pin);
        end
    endfunction

    io34_sync #(
        .W(8)
    ) u_sync_p3 (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .async_in(p3_in),
        .sync_out(p3_pin)
    );

    io34_sync #(
        .W(4)
    ) u_sync_p4 (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .async_in(p4_in),
        .sync_out(p4_pin)
    );

    assign mode_hiz = (op_mode == `IO34_MODE_STANDBY);
    assign mode_hold = (op_mode == `IO34_MODE_SLEEP) ||
                       (op_mode == `IO34_MODE_SUBSLEEP) ||
                       (op_mode == `IO34_MODE_WATCH);

    // Register writes
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            port3_function_select_r <= `IO34_P3_FUNC_RESET;
            port3_data_r <= `IO34_P3_DATA_RESET;
            port3_direction_r <= `IO34_P3_DIR_RESET;
            port3_pullup_enable_r <= `IO34_P3_PULLUP_RESET;
            port4_data_r <= P4_RESET[2:0];
            port4_direction_r <= P4_RESET[2:0];
        end else if (ce && wr) begin
            case (addr)
                `IO34_ADDR_P3_FUNC: begin
                    port3_function_select_r <= wdata;
                end
                `IO34_ADDR_P3_DATA: begin
                    port3_data_r <= wdata;
                end
                `IO34_ADDR_P3_DIR: begin
                    port3_direction_r <= wdata;
                end
                `IO34_ADDR_P3_PULLUP: begin
                    port3_pullup_enable_r <= wdata;
                end
                `IO34_ADDR_P4_DATA: begin
                    port4_data_r <= wdata[2:0];
                end
                `IO34_ADDR_P4_DIR: begin
                    port4_direction_r <= wdata[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data for the cycle after the strobe
    always @* begin
        rdata_nxt = `IO34_UNMAPPED_READ;
        case (addr)
            `IO34_ADDR_P3_FUNC: begin
                rdata_nxt = port3_function_select_r;
            end
            `IO34_ADDR_P3_DATA: begin
                rdata_nxt = io34_read_mux(port3_direction_r, port3_data_r,
                                          p3_pin);
            end
            `IO34_ADDR_P3_DIR: begin
                rdata_nxt = port3_direction_r;
            end
            `IO34_ADDR_P3_PULLUP: begin
                rdata_nxt = port3_pullup_enable_r;
            end
            `IO34_ADDR_P4_DATA: begin
                // Bit 3 is input only, so it always reads the pin
                rdata_nxt = io34_read_mux({5'h1E, port4_direction_r},
                                          {5'h1F, port4_data_r},
                                          {4'hF, p4_pin});
            end
            `IO34_ADDR_P4_DIR: begin
                rdata_nxt = 8'hFF;
            end
            default: begin
                rdata_nxt = `IO34_UNMAPPED_READ;
            end
        endcase
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= rd ? rdata_nxt : 8'h00;
        end
    end

    // Port 3 pin direction and value
    always @* begin
        p3_out_nxt = port3_data_r;
        p3_oe_nxt = port3_direction_r;
        serial2_clock_select_as_out = (serial2_clock_source != `IO34_SERIAL2_CLOCK_SELECT_EXT_SRC);
        if (port3_function_select_r[`IO34_F_SERIAL1_CLOCK_SELECT]) begin
            p3_oe_nxt[0] = ~serial1_clock_source;
            p3_out_nxt[0] = ser1_clk_out;
        end
        if (port3_function_select_r[`IO34_F_SI1]) begin
            p3_oe_nxt[1] = 1'b0;
        end
        if (port3_function_select_r[`IO34_F_SO1]) begin
            p3_oe_nxt[2] = 1'b1;
            p3_out_nxt[2] = ser1_data_out;
        end
        if (port3_function_select_r[`IO34_F_SERIAL2_CLOCK_SELECT]) begin
            p3_oe_nxt[3] = serial2_clock_select_as_out;
            p3_out_nxt[3] = ser2_clk_out;
        end
        if (port3_function_select_r[`IO34_F_SI2]) begin
            p3_oe_nxt[4] = 1'b0;
        end
        if (port3_function_select_r[`IO34_F_SO2]) begin
            p3_oe_nxt[5] = 1'b1;
            p3_out_nxt[5] = ser2_data_out;
        end
        p3_pu_nxt = ~port3_direction_r & port3_pullup_enable_r;
        if (mode_hiz) begin
            p3_oe_nxt = 8'h00;
        end
    end

    // Port 4 pin direction and value
    always @* begin
        p4_out_nxt = port4_data_r;
        p4_oe_nxt = port4_direction_r;
        sck3_as_in = serial3_clk_en[1];
        sck3_as_out = ~serial3_clk_en[1] &
                      (serial3_clk_en[0] | serial3_sync_mode);
        if (serial3_tx_en) begin
            p4_oe_nxt[2] = 1'b1;
            p4_out_nxt[2] = ser3_txd;
        end
        if (serial3_rx_en) begin
            p4_oe_nxt[1] = 1'b0;
        end
        if (sck3_as_in) begin
            p4_oe_nxt[0] = 1'b0;
        end else if (sck3_as_out) begin
            p4_oe_nxt[0] = 1'b1;
            p4_out_nxt[0] = ser3_clk_out;
        end
        if (mode_hiz) begin
            p4_oe_nxt = 3'h0;
        end
    end

    // Pin registers: tri-stated in reset, frozen in the hold modes
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            p3_out <= 8'h00;
            p3_oe <= 8'h00;
            p3_pullup_on <= 8'h00;
            p4_out <= 3'h0;
            p4_oe <= 3'h0;
        end else if (ce && !mode_hold) begin
            p3_out <= p3_out_nxt;
            p3_oe <= p3_oe_nxt;
            p3_pullup_on <= p3_pu_nxt;
            p4_out <= p4_out_nxt;
            p4_oe <= p4_oe_nxt;
        end
    end

    // Serial inputs from the pins, quiet high when the pin is not theirs
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ser1_data_in <= 1'b1;
            ser1_clk_in <= 1'b1;
            ser2_data_in <= 1'b1;
            ser2_clk_in <= 1'b1;
            ser3_rxd <= 1'b1;
            ser3_clk_in <= 1'b1;
        end else if (ce) begin
            ser1_data_in <= port3_function_select_r[`IO34_F_SI1] ? p3_pin[1] : 1'b1;
            ser1_clk_in <= (port3_function_select_r[`IO34_F_SERIAL1_CLOCK_SELECT] &
                            serial1_clock_source) ? p3_pin[0] : 1'b1;
            ser2_data_in <= port3_function_select_r[`IO34_F_SI2] ? p3_pin[4] : 1'b1;
            ser2_clk_in <= (port3_function_select_r[`IO34_F_SERIAL2_CLOCK_SELECT] &
                            ~serial2_clock_select_as_out) ? p3_pin[3] : 1'b1;
            ser3_rxd <= serial3_rx_en ? p4_pin[1] : 1'b1;
            ser3_clk_in <= sck3_as_in ? p4_pin[0] : 1'b1;
        end
    end
endmodule // io34_top
`default_nettype wire

// *** io34_top_test.sv ***
// Self-checking bench for the port 3 / port 4 I/O block
`timescale 1ns/1ps
`default_nettype none
`include "io34_defs.vh"
module io34_top_test;
    localparam logic [15:0] P3F = `IO34_ADDR_P3_FUNC;
    localparam logic [15:0] P3C = `IO34_ADDR_P3_DIR;
    localparam logic [15:0] P3U = `IO34_ADDR_P3_PULLUP;
    localparam logic [15:0] P4D = `IO34_ADDR_P4_DATA;
    localparam logic [15:0] P4C = `IO34_ADDR_P4_DIR;
    logic mclk, rstn, ce, wr, rd, s1_src, tx_en, rx_en;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, p3_out, p3_oe, p3_pu, p3_in;
    logic [2:0] op_mode, s2_src, p4_out, p4_oe;
    logic [1:0] clk_en;
    logic [5:0] ser = 6'h00;
    logic [3:0] p4_in, p4_ext;
    wire [5:0] sin;
    logic [67:0] rows [13];
    logic [67:0] row;
    int errors, checks;
    io34_top dut (.mclk(mclk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .op_mode(op_mode), .serial1_clock_source(s1_src),
        .serial2_clock_source(s2_src), .serial3_tx_en(tx_en), .serial3_rx_en(rx_en),
        .serial3_clk_en(clk_en), .serial3_sync_mode(1'b0), .ser1_data_out(ser[0]),
        .ser1_clk_out(ser[1]), .ser2_data_out(ser[2]), .ser2_clk_out(ser[3]),
        .ser3_txd(ser[4]), .ser3_clk_out(ser[5]), .ser1_data_in(sin[0]), .ser1_clk_in(sin[1]),
        .ser2_data_in(sin[2]), .ser2_clk_in(sin[3]), .ser3_rxd(sin[4]), .ser3_clk_in(sin[5]),
        .p3_in(p3_in), .p3_out(p3_out), .p3_oe(p3_oe), .p3_pullup_on(p3_pu), .p4_in(p4_in),
        .p4_out(p4_out), .p4_oe(p4_oe));
    io34_pins pins (.p3_out(p3_out), .p3_oe(p3_oe), .p3_pullup_on(p3_pu), .p4_out(p4_out),
        .p4_oe(p4_oe), .p4_ext(p4_ext), .p3_in(p3_in), .p4_in(p4_in));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) ser <= ser + 6'h01;
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk("rdata", rdata, e);
    endtask
    task automatic give_verdict;
        if (errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic settle;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    initial begin
        #400000;
        errors++;
        give_verdict;
    end
    initial begin
        {wr, rd, s1_src, tx_en, rx_en, addr, wdata, clk_en} = '0;
        ce = 1'b1;
        p4_ext = 4'hD;
        op_mode = `IO34_MODE_ACTIVE;
        s2_src = 3'h7;
        rstn = 1'b0;
        // Columns: write addr, data, read addr, read value, clock sources, p3_oe, pull-ups
        rows = '{{16'h0000, 8'h55, 16'h0000, 8'h00, 4'h7, 8'h00, 8'h00},
            {P4C, 8'h07, P4D, 8'hF8, 4'h7, 8'h00, 8'h00}, {P4D, 8'h02, P4D, 8'hFA, 4'h7, 8'h00, 8'h00},
            {P4C, 8'h00, P4D, 8'hFD, 4'h7, 8'h00, 8'h00}, {P3U, 8'hFF, P3U, 8'hFF, 4'h7, 8'h00, 8'hFF},
            {P3C, 8'h0F, P3C, 8'h0F, 4'h7, 8'h0F, 8'hF0}, {P3F, 8'h24, P3F, 8'h24, 4'h7, 8'h2F, 8'hF0},
            {P3C, 8'h00, P3C, 8'h00, 4'h7, 8'h24, 8'hFF}, {P3F, 8'h09, P3F, 8'h09, 4'h7, 8'h01, 8'hFF},
            {P3F, 8'h09, P3F, 8'h09, 4'h8, 8'h08, 8'hFF}, {P3C, 8'h10, P3C, 8'h10, 4'h7, 8'h11, 8'hEF},
            {P3F, 8'h10, P3F, 8'h10, 4'h7, 8'h00, 8'hEF}, {P3C, 8'hFF, P3C, 8'hFF, 4'h7, 8'hEF, 8'h00}};
        repeat (12) @(posedge mclk);
        #1;
        chk("p3_oe", p3_oe, 8'h00);
        @(posedge mclk);
        rstn <= 1'b1;
        rd_chk(P3F, 8'h00);
        rd_chk(P4C, 8'hFF);
        rd_chk(P3U, 8'h00);
        chk("p3_pullup_on", p3_pu, 8'h00);
        foreach (rows[i]) begin
            row = rows[i];
            @(posedge mclk);
            s1_src <= row[19];
            s2_src <= row[18:16];
            wr_reg(row[67:52], row[51:44]);
            repeat (4) @(posedge mclk);
            rd_chk(row[43:28], row[27:20]);
            chk("p3_oe", p3_oe, row[15:8]);
            chk("p3_pullup_on", p3_pu, row[7:0]);
        end
        // Drive input-only bit 3 low so it differs from the stored ones
        @(posedge mclk);
        p4_ext <= 4'h5;
        settle;
        rd_chk(P4D, 8'hF5);
        @(posedge mclk);
        op_mode <= `IO34_MODE_SLEEP;
        wr_reg(P3C, 8'h00);
        settle;
        chk("p3_oe", p3_oe, 8'hEF);
        @(posedge mclk);
        op_mode <= `IO34_MODE_STANDBY;
        settle;
        chk("p3_oe", p3_oe, 8'h00);
        chk("p3_in", p3_in, 8'hFF);
        chk("p3_pullup_on", p3_pu, 8'hFF);
        @(posedge mclk);
        op_mode <= `IO34_MODE_ACTIVE;
        wr_reg(P4C, 8'h07);
        settle;
        chk("p4_oe", {5'h00, p4_oe}, 8'h07);
        chk("p4_out", {5'h00, p4_out}, 8'h02);
        @(posedge mclk);
        tx_en <= 1'b1;
        rx_en <= 1'b1;
        clk_en <= 2'b10;
        settle;
        chk("p4_oe", {5'h00, p4_oe}, 8'h04);
        // Floating bit 4 settles low, so the serial input must follow it
        wr_reg(P3U, 8'h00);
        wr_reg(`IO34_ADDR_P3_DATA, 8'h10);
        settle;
        settle;
        chk("ser_in", {2'h0, sin}, 8'h2B);
        chk("p3_out", p3_out, 8'h10);
        // A write with the clock enable low must leave the register alone
        @(posedge mclk);
        ce <= 1'b0;
        wr_reg(P3F, 8'h00);
        ce <= 1'b1;
        rd_chk(P3F, 8'h10);
        give_verdict;
    end
endmodule // io34_top_test
`default_nettype wire
